// ---- pkg/dfo_defs.svh ----
// constants for the decrement-file-register execution datapath
// assumes one mclk_i edge per phase, four phases per instruction cycle
// Notes on behaviour
// RULE1: recognise fixed opcode bits, then destination bit, then seven-bit file address
// RULE2: read the addressed file register and compute its contents minus one
// RULE3: destination bit clear: result goes to accumulator, file register untouched
// RULE4: destination bit set: result written back into the same file register
// RULE5: decode, read, arithmetic, write in four sequential phases of one cycle
// RULE6: only the zero flag changes; every other status bit is kept
// RULE7: zero flag set when the 8-bit result is zero, else cleared
`ifndef DFO_DEFS_SVH
`define DFO_DEFS_SVH
`define DFO_OPC_HI 13
`define DFO_OPC_LO 8
`define DFO_OPC_VAL 6'h03
`define DFO_DEST_BIT 7
`define DFO_ADDR_HI 6
`define DFO_ADDR_LO 0
`define DFO_Z_BIT 2
`define DFO_W_RST 8'h00
`define DFO_STATUS_RST 8'h00
`define DFO_DEC_STEP 8'h01
`endif

// ---- pkg/dfo_pkg.sv ----
// types shared by the decrement datapath modules
// assumes dfo_defs.svh is on the include path
package dfo_pkg;
    typedef enum logic [1:0] {
        DFO_Q1 = 2'b00,
        DFO_Q2 = 2'b01,
        DFO_Q3 = 2'b10,
        DFO_Q4 = 2'b11
    } dfo_phase_t;
endpackage : dfo_pkg

// ---- rtl/dfo_dec.sv ----
// decrement-by-one unit with zero detect
// assumes a purely combinational use inside one phase
`timescale 1ns/1ps
`include "dfo_defs.svh"
module dfo_dec #(
    parameter int DW = 8
) (
    input wire logic [DW-1:0] a_i,
    output logic [DW-1:0] y_o,
    output logic zero_o
);
    // wraps 0x00 to all ones, as the core does
    assign y_o = a_i - DW'(`DFO_DEC_STEP); // RULE2
    assign zero_o = (y_o == '0); // RULE7
endmodule : dfo_dec

// ---- rtl/dfo_exec.sv ----
// execution datapath of the decrement-file-register instruction
// assumes file memory answers reads in the same phase and the core
// presents the instruction word during the first phase
`timescale 1ns/1ps
`include "dfo_defs.svh"
module dfo_exec #(
    parameter int DW = 8,
    parameter int AW = 7,
    parameter int IW = 14
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic instr_valid_i,
    input wire logic [IW-1:0] instr_i,
    input wire logic [DW-1:0] file_rd_data_i,
    input wire logic [DW-1:0] status_i,
    output dfo_pkg::dfo_phase_t phase_o,
    output logic op_active_o,
    output logic file_rd_en_o,
    output logic [AW-1:0] file_addr_o,
    output logic file_wr_en_o,
    output logic [DW-1:0] file_wr_data_o,
    output logic [DW-1:0] w_o,
    output logic status_wr_en_o,
    output logic [DW-1:0] status_wr_data_o
);
    import dfo_pkg::*;

    typedef struct packed {
        dfo_phase_t phase;
        logic op;
        logic dest;
        logic [AW-1:0] addr;
        logic [DW-1:0] operand;
        logic [DW-1:0] result;
        logic [DW-1:0] status;
        logic [DW-1:0] w;
    } dfo_state_t;

    dfo_state_t state_q;
    dfo_state_t state_d;
    logic [DW-1:0] dec_y;
    logic dec_zero;
    logic opc_hit;

    dfo_dec #(
        .DW(DW)
    ) u_dec (
        .a_i(state_q.operand),
        .y_o(dec_y),
        .zero_o(dec_zero)
    );

    assign opc_hit = instr_valid_i &&
        (instr_i[`DFO_OPC_HI:`DFO_OPC_LO] == `DFO_OPC_VAL); // RULE1

    always_comb begin
        state_d = state_q;
        // free-running phase counter, one step per clock
        case (state_q.phase)
            DFO_Q1: begin
                state_d.phase = DFO_Q2; // RULE5
                state_d.op = opc_hit; // RULE1
                if (opc_hit) begin
                    state_d.dest = instr_i[`DFO_DEST_BIT];
                    state_d.addr = instr_i[`DFO_ADDR_HI:`DFO_ADDR_LO];
                end
            end
            DFO_Q2: begin
                state_d.phase = DFO_Q3; // RULE5
                if (state_q.op) begin
                    state_d.operand = file_rd_data_i; // RULE2
                end
            end
            DFO_Q3: begin
                state_d.phase = DFO_Q4; // RULE5
                if (state_q.op) begin
                    state_d.result = dec_y; // RULE2
                    // status sampled late so earlier writes by the core are kept
                    state_d.status = status_i; // RULE6
                    state_d.status[`DFO_Z_BIT] = dec_zero; // RULE7
                end
            end
            DFO_Q4: begin
                state_d.phase = DFO_Q1; // RULE5
                if (state_q.op && !state_q.dest) begin
                    state_d.w = state_q.result; // RULE3
                end
                state_d.op = 1'b0;
            end
            default: begin
                state_d.phase = DFO_Q1;
                state_d.op = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q.phase <= DFO_Q1;
            state_q.op <= 1'b0;
            state_q.dest <= 1'b0;
            state_q.addr <= '0;
            state_q.operand <= '0;
            state_q.result <= '0;
            state_q.status <= DW'(`DFO_STATUS_RST);
            state_q.w <= DW'(`DFO_W_RST);
        end else begin
            state_q <= state_d;
        end
    end

    assign phase_o = state_q.phase;
    assign op_active_o = state_q.op;
    assign file_addr_o = state_q.addr;
    assign file_wr_data_o = state_q.result;
    assign w_o = state_q.w;
    assign status_wr_data_o = state_q.status;
    assign file_rd_en_o = state_q.op && (state_q.phase == DFO_Q2); // RULE2
    // write strobes only in the last phase
    assign file_wr_en_o = state_q.op && state_q.dest && (state_q.phase == DFO_Q4); // RULE4
    assign status_wr_en_o = state_q.op && (state_q.phase == DFO_Q4); // RULE7

    // assertions, sampled on every phase edge
    localparam logic [DW-1:0] ZMASK = DW'(1) << `DFO_Z_BIT;

    sequence s_decode_hit;
        (state_q.phase == DFO_Q1) && opc_hit;
    endsequence

    sequence s_four_phases;
        (state_q.phase == DFO_Q1) ##1 (state_q.phase == DFO_Q2) ##1
        (state_q.phase == DFO_Q3) ##1 (state_q.phase == DFO_Q4);
    endsequence

    sequence s_read_phase;
        state_q.op && (state_q.phase == DFO_Q2);
    endsequence

    sequence s_write_phase;
        state_q.op && (state_q.phase == DFO_Q4);
    endsequence

    a_decode_match: assert property ( // RULE1
        @(posedge mclk_i) disable iff (!arst_n_i)
        s_decode_hit |=> state_q.op && (file_addr_o == $past(instr_i[`DFO_ADDR_HI:`DFO_ADDR_LO]))
    ) else $error("decrement opcode not taken");

    a_decode_reject: assert property ( // RULE1
        @(posedge mclk_i) disable iff (!arst_n_i)
        ((state_q.phase == DFO_Q1) && !opc_hit) |-> ##3 !file_wr_en_o && !status_wr_en_o
    ) else $error("write strobe without decrement opcode");

    a_read_result: assert property ( // RULE2
        @(posedge mclk_i) disable iff (!arst_n_i)
        s_read_phase |-> file_rd_en_o ##2 (file_wr_data_o == $past(file_rd_data_i, 2) - DW'(1))
    ) else $error("result is not operand minus one");

    a_dest_w: assert property ( // RULE3
        @(posedge mclk_i) disable iff (!arst_n_i)
        (state_q.op && !state_q.dest && (state_q.phase == DFO_Q4))
            |-> !file_wr_en_o ##1 (w_o == $past(file_wr_data_o))
    ) else $error("accumulator destination mishandled");

    a_dest_file: assert property ( // RULE4
        @(posedge mclk_i) disable iff (!arst_n_i)
        (state_q.op && state_q.dest && (state_q.phase == DFO_Q4))
            |-> file_wr_en_o && (file_addr_o == $past(file_addr_o, 2)) ##1 $stable(w_o)
    ) else $error("file destination mishandled");

    a_phase_order: assert property ( // RULE5
        @(posedge mclk_i) disable iff (!arst_n_i)
        (state_q.phase == DFO_Q1) |-> s_four_phases ##1 (state_q.phase == DFO_Q1)
    ) else $error("phase sequence broken");

    a_status_keep: assert property ( // RULE6
        @(posedge mclk_i) disable iff (!arst_n_i)
        status_wr_en_o |-> ((status_wr_data_o & ~ZMASK) == ($past(status_i) & ~ZMASK))
    ) else $error("non-zero status bits altered");

    a_zero_flag: assert property ( // RULE7
        @(posedge mclk_i) disable iff (!arst_n_i)
        status_wr_en_o |-> (status_wr_data_o[`DFO_Z_BIT] == (file_wr_data_o == '0))
    ) else $error("zero flag wrong");

    a_read_window: assert property ( // RULE2
        @(posedge mclk_i) disable iff (!arst_n_i)
        file_rd_en_o |-> (phase_o == DFO_Q2) && op_active_o
    ) else $error("read strobe outside read phase");

    a_read_single: assert property ( // RULE5
        @(posedge mclk_i) disable iff (!arst_n_i)
        file_rd_en_o |=> !file_rd_en_o
    ) else $error("read strobe longer than one phase");

    a_write_window: assert property ( // RULE4
        @(posedge mclk_i) disable iff (!arst_n_i)
        file_wr_en_o |-> (phase_o == DFO_Q4) && status_wr_en_o
    ) else $error("file write outside write phase");

    a_write_single: assert property ( // RULE5
        @(posedge mclk_i) disable iff (!arst_n_i)
        status_wr_en_o |=> !status_wr_en_o && !file_wr_en_o
    ) else $error("write strobe longer than one phase");

    a_w_steady: assert property ( // RULE3
        @(posedge mclk_i) disable iff (!arst_n_i)
        !(status_wr_en_o && !file_wr_en_o) |=> $stable(w_o)
    ) else $error("accumulator changed without a decrement to it");

    a_op_start: assert property ( // RULE5
        @(posedge mclk_i) disable iff (!arst_n_i)
        $rose(op_active_o) |-> (phase_o == DFO_Q2) && file_rd_en_o
    ) else $error("decrement started outside read phase");

    a_op_end: assert property ( // RULE5
        @(posedge mclk_i) disable iff (!arst_n_i)
        s_write_phase |=> !op_active_o && (phase_o == DFO_Q1)
    ) else $error("decrement outlived its cycle");

    a_zero_operand: assert property ( // RULE7
        @(posedge mclk_i) disable iff (!arst_n_i)
        status_wr_en_o |-> (status_wr_data_o[`DFO_Z_BIT] == ($past(file_rd_data_i, 2) == DW'(1)))
    ) else $error("zero flag disagrees with operand");

    a_addr_steady: assert property ( // RULE4
        @(posedge mclk_i) disable iff (!arst_n_i)
        (op_active_o && (phase_o != DFO_Q2)) |-> $stable(file_addr_o)
    ) else $error("file address moved during decrement");

endmodule : dfo_exec

// ---- testbench/test_decrement_file_register_op.sv ----
// self-checking bench for the decrement execution datapath
// assumes the bench plays fetch, file memory and status register
`timescale 1ns/1ps
`include "dfo_defs.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("Error %s expected %h seen %h", n, e, g); end end
module test_decrement_file_register_op;
    import dfo_pkg::*;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic instr_valid_i = 1'b0;
    logic [13:0] instr_i = 14'h0000;
    logic [7:0] file_rd_data_i = 8'h00;
    logic [7:0] status_i = 8'h00;
    dfo_phase_t phase_o;
    logic op_active_o, file_rd_en_o, file_wr_en_o, status_wr_en_o;
    logic [6:0] file_addr_o;
    logic [7:0] file_wr_data_o, w_o, status_wr_data_o;
    int fails = 0;
    int num_checks = 0;
    logic [7:0] w_m = `DFO_W_RST;
    int mem_m [0:127];
    int res_q [$];
    logic [5:0] opc;
    always #50 mclk_i = ~mclk_i;
    dfo_exec #(.DW(8), .AW(7), .IW(14)) u_dfo_exec (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .file_rd_data_i(file_rd_data_i), .status_i(status_i), .phase_o(phase_o),
        .op_active_o(op_active_o), .file_rd_en_o(file_rd_en_o), .file_addr_o(file_addr_o),
        .file_wr_en_o(file_wr_en_o), .file_wr_data_o(file_wr_data_o), .w_o(w_o),
        .status_wr_en_o(status_wr_en_o), .status_wr_data_o(status_wr_data_o)
    );
    task results;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    // one full instruction cycle; bench memory model answers the read
    task run_op(input logic [13:0] ins, input logic [7:0] st);
        logic hit;
        int res;
        logic [7:0] st_m;
        hit = (ins[13:8] === `DFO_OPC_VAL);
        res = (mem_m[ins[6:0]] + 9'h100 - `DFO_DEC_STEP) % 9'h100;
        st_m = st;
        st_m[`DFO_Z_BIT] = (res == 32'h0);
        if (hit) res_q.push_back(res);
        // sample phase mid-cycle, then drive on the edge that opens decode
        do @(negedge mclk_i); while (phase_o !== DFO_Q4);
        @(posedge mclk_i);
        instr_valid_i <= 1'b1;
        instr_i <= ins;
        file_rd_data_i <= 8'(mem_m[ins[6:0]]);
        status_i <= st;
        @(posedge mclk_i);
        instr_valid_i <= 1'b0;
        @(negedge mclk_i);
        `CHK("rd_en", hit, file_rd_en_o)
        `CHK("active", hit, op_active_o)
        `CHK("phase", DFO_Q2, phase_o)
        if (hit) `CHK("addr", ins[6:0], file_addr_o)
        @(negedge mclk_i);
        `CHK("rd_en_q3", 1'b0, file_rd_en_o)
        @(negedge mclk_i);
        `CHK("wr_en", hit & ins[7], file_wr_en_o)
        `CHK("st_en", hit, status_wr_en_o)
        if (hit) begin
            res = res_q.pop_front();
            `CHK("wr_data", 8'(res), file_wr_data_o)
            `CHK("status", st_m, status_wr_data_o)
            if (ins[7]) mem_m[ins[6:0]] = res;
            else w_m = 8'(res);
        end
        @(negedge mclk_i);
        `CHK("w", w_m, w_o)
        if (hit) `CHK("st_bits", st[7:3], status_wr_data_o[7:3])
        $display("op %h done", ins);
    endtask : run_op
    // decrement shown outside the decode phase must be ignored
    task run_stray;
        do @(negedge mclk_i); while (phase_o !== DFO_Q1);
        @(posedge mclk_i);
        instr_valid_i <= 1'b1;
        instr_i <= {6'h03, 1'b1, 7'h05};
        @(negedge mclk_i);
        `CHK("stray_rd", 1'b0, file_rd_en_o)
        @(posedge mclk_i);
        @(posedge mclk_i);
        instr_valid_i <= 1'b0;
        @(negedge mclk_i);
        `CHK("stray_wr", 1'b0, file_wr_en_o | status_wr_en_o)
        $display("stray op done");
    endtask : run_stray
    initial begin
        void'($urandom(32090));
        foreach (mem_m[i]) mem_m[i] = $urandom % 9'h100;
        mem_m[7'h0C] = 8'h01;
        mem_m[7'h7F] = 8'h00;
        repeat (10) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        @(negedge mclk_i);
        `CHK("w_rst", `DFO_W_RST, w_o)
        run_op({6'h03, 1'b1, 7'h0C}, 8'hFB);
        // reads back the zero just written, wraps to all ones
        run_op({6'h03, 1'b0, 7'h0C}, 8'h04);
        run_op({6'h03, 1'b0, 7'h7F}, 8'h04);
        run_op({6'h0A, 1'b0, 7'h10}, 8'h00);
        run_stray();
        @(posedge mclk_i);
        arst_n_i <= 1'b0;
        @(negedge mclk_i);
        `CHK("w_rst2", `DFO_W_RST, w_o)
        `CHK("ph_rst", DFO_Q1, phase_o)
        w_m = `DFO_W_RST;
        @(posedge mclk_i);
        arst_n_i <= 1'b1;
        repeat (30) begin
            // mostly decrements, some foreign opcodes that must do nothing
            opc = ($urandom % 4 == 0) ? 6'($urandom) : 6'h03;
            run_op({opc, 8'($urandom)}, 8'($urandom));
        end
        results();
    end
    initial begin
        #200000;
        fails++;
        results();
    end
endmodule : test_decrement_file_register_op
